/* File: ssp_host_model.sv */
// ssp_host_model: baseband side of the three-wire programming bus
// assumes: pins idle high, serial clock period 64 ns
`timescale 1ns/10ps
module ssp_host_model (
   output logic ser_clk,
   output logic ser_data,
   output logic ser_en_n
);
   initial begin
      ser_clk = 1'b1;
      ser_data = 1'b1;
      ser_en_n = 1'b1;
   end
   task automatic send(input logic [31:0] w, input int n);
      ser_en_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         ser_clk = 1'b0;
         ser_data = w[i];
         #32;
         ser_clk = 1'b1;
         #32;
      end
      ser_en_n = 1'b1;
      ser_data = 1'b1;
   endtask : send
endmodule : ssp_host_model

/* File: ssp_pkg.sv */
// ssp_pkg: constants for the synthesizer serial programming port
// assumes: single 200 MHz system clock; serial word layout fixed at 24 bits
package ssp_pkg;
   // ****************************************
   // word layout
   // ****************************************
   localparam int WORD_BITS = 24;
   localparam int ADDR_BITS = 8;
   localparam int DATA_BITS = 16;
   localparam int DATA_MSB  = 15;
   localparam int CNT_BITS  = 5;
   localparam logic [CNT_BITS-1:0] WORD_CNT = 5'h18;
   // ****************************************
   // addresses of the three programming words
   // ****************************************
   localparam logic [7:0] ADDR_SBAND = 8'h01;
   localparam logic [7:0] ADDR_UHF   = 8'h02;
   localparam logic [7:0] ADDR_SEL   = 8'h03;
   // ****************************************
   // field layout of a synthesizer word
   // ****************************************
   localparam int FRAC_LSB = 0;
   localparam int FRAC_W   = 5;
   localparam int SWAL_LSB = 5;
   localparam int SWAL_W   = 3;
   localparam int INT_LSB  = 8;
   localparam int INT_W    = 8;
   localparam logic [FRAC_W-1:0] FRAC_MAX = 5'h11;
   // ****************************************
   // select word bits
   // ****************************************
   localparam int EDGE_BIT = 0;
   localparam int FILT_BIT = 1;
   // ****************************************
   // reset values and frequency constants
   // ****************************************
   localparam logic [DATA_BITS-1:0] WORD_RST = 16'h0000;
   localparam int MUL_INT   = 8;
   localparam int INT_OFS   = 3;
   localparam int FRAC_DIV  = 18;
   localparam int UHF_DIV   = 8;
   localparam int REF_KHZ   = 18000;
   localparam int SBAND_STEP_KHZ = 1000;
   localparam int UHF_STEP_KHZ   = 125;
   localparam int DIV_W     = 16;
endpackage : ssp_pkg

/* File: ssp_port.sv */
// ssp_port: three-wire serial programming port for two fractional synthesizers
// assumes: serial pins asynchronous to sys_clk, far slower than 200 MHz
`timescale 1ns/10ps
module ssp_port
   import ssp_pkg::*;
#(
   parameter int REF_FREQ_KHZ = REF_KHZ
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire logic                 ser_clk,
   input  wire logic                 ser_data,
   input  wire logic                 ser_en_n,
   output logic                      edge_polarity_select,
   output logic                      filter_path_select,
   output logic [DIV_W-1:0]          sband_ratio_x144,
   output logic [DIV_W-1:0]          uhf_ratio_x144,
   output logic                      uhf_ref_half,
   output logic [DIV_W-1:0]          sband_step_khz,
   output logic [DIV_W-1:0]          uhf_step_khz,
   output logic                      config_done,
   output logic                      frac_error
);
   // ****************************************
   // pin synchronisers, reset to idle high
   // ****************************************
   logic [2:0] s1_q;
   logic [2:0] s2_q;
   logic       clk_prev_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s1_q       <= 3'h7;
         s2_q       <= 3'h7;
         clk_prev_q <= 1'b1;
      end else begin
         s1_q       <= {ser_en_n, ser_data, ser_clk};
         s2_q       <= s1_q;
         clk_prev_q <= s2_q[0];
      end
   end
   // ****************************************
   // synchronised pins and clock edge
   // ****************************************
   wire clk_s  = s2_q[0];
   wire data_s = s2_q[1];
   wire en_act = ~s2_q[2];
   wire rise   = clk_s & ~clk_prev_q;
   // ****************************************
   // shift register
   // ****************************************
   logic [WORD_BITS-1:0] shift_q;
   logic [CNT_BITS-1:0]  cnt_q;
   logic                 en_prev_q;
   wire                  latch = en_prev_q & ~en_act;
   wire                  full  = (cnt_q == WORD_CNT);
   wire                  spent = (cnt_q > WORD_CNT);
   wire                  apply = latch & full;
   wire [ADDR_BITS-1:0]  w_addr = shift_q[WORD_BITS-1 -: ADDR_BITS];
   wire [DATA_BITS-1:0]  w_data = shift_q[DATA_MSB:0];
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         shift_q <= '0;
      end else if (en_act && rise) begin
         shift_q <= {shift_q[WORD_BITS-2:0], data_s};
      end
   end
   // ****************************************
   // bit counter, held once past a full word
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (!en_act) begin
         cnt_q <= '0;
      end else if (rise && !spent) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end
   // ****************************************
   // latch enable edge
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         en_prev_q <= 1'b0;
      end else begin
         en_prev_q <= en_act;
      end
   end
   // ****************************************
   // word decode and storage
   // ****************************************
   wire                  wr_sband = apply & (w_addr == ADDR_SBAND);
   wire                  wr_uhf   = apply & (w_addr == ADDR_UHF);
   wire                  wr_sel   = apply & (w_addr == ADDR_SEL);
   wire [2:0]            wr_hit   = {wr_sel, wr_uhf, wr_sband};
   logic [DATA_BITS-1:0] sband_q;
   logic [DATA_BITS-1:0] uhf_q;
   logic [DATA_BITS-1:0] sel_q;
   logic [2:0]           seen_q;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sband_q <= WORD_RST;
      end else if (wr_sband) begin
         sband_q <= w_data;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         uhf_q <= WORD_RST;
      end else if (wr_uhf) begin
         uhf_q <= w_data;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sel_q <= WORD_RST;
      end else if (wr_sel) begin
         sel_q <= w_data;
      end
   end
   // ****************************************
   // words seen since reset
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         seen_q <= 3'h0;
      end else begin
         seen_q <= seen_q | wr_hit;
      end
   end
   // ****************************************
   // divider ratio, scaled by 18 to stay integer
   // ****************************************
   function automatic logic [DIV_W-1:0] ratio_x18(input logic [DATA_BITS-1:0] w);
      logic [31:0] n;
      logic [31:0] s;
      logic [31:0] f;
      n = 32'(w[INT_LSB +: INT_W]);
      s = 32'(w[SWAL_LSB +: SWAL_W]);
      f = 32'(w[FRAC_LSB +: FRAC_W]);
      ratio_x18 = DIV_W'(FRAC_DIV * (MUL_INT * (n + INT_OFS) - s) - f);
   endfunction : ratio_x18
   // ****************************************
   // fraction range check
   // ****************************************
   function automatic logic frac_bad(input logic [DATA_BITS-1:0] w);
      frac_bad = w[FRAC_LSB +: FRAC_W] > FRAC_MAX;
   endfunction : frac_bad
   // ****************************************
   // decoded ratios of the stored words
   // ****************************************
   wire [DIV_W-1:0] sb_r  = ratio_x18(sband_q);
   wire [DIV_W-1:0] uh_r  = ratio_x18(uhf_q);
   // ****************************************
   // step sizes against the reference
   // ****************************************
   wire [31:0]      sb_st = (SBAND_STEP_KHZ * REF_FREQ_KHZ) / REF_KHZ;
   wire [31:0]      uh_st = (UHF_STEP_KHZ * REF_FREQ_KHZ) / REF_KHZ;
   // ****************************************
   // select bits
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         edge_polarity_select <= 1'b0;
         filter_path_select   <= 1'b0;
      end else begin
         edge_polarity_select <= sel_q[EDGE_BIT];
         filter_path_select   <= sel_q[FILT_BIT];
      end
   end
   // ****************************************
   // divider ratios
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sband_ratio_x144 <= '0;
         uhf_ratio_x144   <= '0;
      end else begin
         sband_ratio_x144 <= DIV_W'(sb_r * 16'(UHF_DIV));
         uhf_ratio_x144   <= uh_r;
      end
   end
   // ****************************************
   // reference flag and step sizes
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         uhf_ref_half   <= 1'b0;
         sband_step_khz <= '0;
         uhf_step_khz   <= '0;
      end else begin
         uhf_ref_half   <= 1'b1;
         sband_step_khz <= DIV_W'(sb_st);
         uhf_step_khz   <= DIV_W'(uh_st);
      end
   end
   // ****************************************
   // status flags
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         config_done <= 1'b0;
         frac_error  <= 1'b0;
      end else begin
         config_done <= &seen_q;
         frac_error  <= frac_bad(sband_q) | frac_bad(uhf_q);
      end
   end
endmodule : ssp_port

/* File: ssp_port_props.sv */
// ssp_port_props: timing and value checks on the serial port outputs
// assumes: bound to ssp_port, one sys_clk domain, sync reset
`timescale 1ns/10ps
module ssp_port_props
   import ssp_pkg::*;
#(
   parameter int REF_FREQ_KHZ = REF_KHZ
) (
   input wire logic             sys_clk,
   input wire logic             rst_n,
   input wire logic             ser_en_n,
   input wire logic             edge_polarity_select,
   input wire logic             filter_path_select,
   input wire logic [DIV_W-1:0] sband_ratio_x144,
   input wire logic [DIV_W-1:0] uhf_ratio_x144,
   input wire logic             uhf_ref_half,
   input wire logic [DIV_W-1:0] sband_step_khz,
   input wire logic [DIV_W-1:0] uhf_step_khz,
   input wire logic             config_done,
   input wire logic             frac_error
);
   logic       en_q;
   logic [4:0] gap_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // cycles since latch enable rose
   always_ff @(posedge sys_clk) begin
      en_q <= ser_en_n;
      if (!rst_n || (gap_q != 5'h1F && !(ser_en_n && !en_q))) begin
         gap_q <= rst_n ? gap_q + 5'h01 : 5'h00;
      end else if (ser_en_n && !en_q) begin
         gap_q <= 5'h00;
      end
   end
   sequence run_on;
      $past(rst_n, 2) && $past(rst_n);
   endsequence
   sequence shifting;
      !ser_en_n [*8];
   endsequence
   ref_half_a: assert property (run_on |-> uhf_ref_half)
      else $error("half reference flag low");
   step_size_a: assert property (run_on |-> sband_step_khz == DIV_W'(1000 * REF_FREQ_KHZ / 18000)
      && uhf_step_khz == DIV_W'(125 * REF_FREQ_KHZ / 18000))
      else $error("step size wrong");
   reset_clear_a: assert property (disable iff (1'b0)
      !$past(rst_n) |-> !config_done && !frac_error && sband_ratio_x144 == 16'h0000)
      else $error("outputs not cleared by reset");
   done_sticky_a: assert property ($past(config_done) |-> config_done)
      else $error("config done dropped");
   sel_window_a: assert property ($changed(edge_polarity_select)
      || $changed(filter_path_select) |-> gap_q inside {[1:12]})
      else $error("select bit changed outside word end");
   ratio_window_a: assert property ($changed(sband_ratio_x144)
      || $changed(uhf_ratio_x144) |-> gap_q inside {[1:12]})
      else $error("ratio changed outside word end");
   flag_window_a: assert property ($changed(config_done)
      || $changed(frac_error) |-> gap_q inside {[1:12]})
      else $error("flag changed outside word end");
   quiet_shift_a: assert property (shifting |-> $stable(sband_ratio_x144)
      && $stable(uhf_ratio_x144) && $stable(edge_polarity_select))
      else $error("output moved while shifting");
endmodule : ssp_port_props
bind ssp_port ssp_port_props #(.REF_FREQ_KHZ(REF_FREQ_KHZ)) ssp_port_props_i (.*);

/* File: tb.sv */
// tb: word-level tests of the serial programming port
// assumes: ssp_port at default reference, host model drives the pins
`timescale 1ns/10ps
module tb;
   import ssp_pkg::*;
   logic             sys_clk, rst_n, ser_clk, ser_data, ser_en_n;
   logic             edge_polarity_select, filter_path_select, uhf_ref_half;
   logic             config_done, frac_error;
   logic [DIV_W-1:0] sband_ratio_x144, uhf_ratio_x144, sband_step_khz, uhf_step_khz;
   int               num_errors, checks_done, cycles;
   ssp_port ssp_port_i (.*);
   ssp_host_model ssp_host_model_i (.*);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic put(input logic [31:0] w, input int n);
      @(posedge sys_clk);
      #1;
      ssp_host_model_i.send(w, n);
      repeat (8) @(posedge sys_clk);
      #1;
   endtask : put
   function automatic logic [15:0] ratio(input int n, s, f, m);
      return 16'(m * (8 * (n + 3) - s) - f * m / 18);
   endfunction : ratio
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish;
      end
   end
   initial begin
      rst_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(sband_step_khz, 16'h03E8);
      chk(uhf_step_khz, 16'h007D);
      chk({15'h0000, uhf_ref_half}, 16'h0001);
      $display("test reset done");
      put({8'h00, ADDR_SBAND, 8'h28, 3'h2, 5'h11}, 24);
      chk(sband_ratio_x144, ratio(40, 2, 17, 144));
      put({8'h00, ADDR_UHF, 8'h2E, 3'h7, 5'h00}, 24);
      chk(uhf_ratio_x144, ratio(46, 7, 0, 18));
      chk({14'h0000, config_done, frac_error}, 16'h0000);
      put({9'h000, ADDR_SBAND, 15'h0000}, 23);
      chk(sband_ratio_x144, ratio(40, 2, 17, 144));
      put({8'h00, 8'h07, 16'h0000}, 24);
      chk(uhf_ratio_x144, ratio(46, 7, 0, 18));
      $display("test synth words done");
      for (int k = 0; k < 4; k++) begin
         put({8'h00, ADDR_SEL, 14'h0000, k[1:0]}, 24);
         chk({14'h0000, filter_path_select, edge_polarity_select}, 16'(k));
      end
      chk({15'h0000, config_done}, 16'h0001);
      put({8'h00, ADDR_UHF, 8'h2E, 3'h7, 5'h12}, 24);
      chk({15'h0000, frac_error}, 16'h0001);
      chk(uhf_ratio_x144, ratio(46, 7, 18, 18));
      $display("test select and fraction done");
      tally_and_finish;
   end
endmodule : tb
